// ===== design/emw_ctrl.sv
// Purpose: ROM window mapping and wait insertion for program and data accesses
// Assumes: CPU holds cpu_req and its attributes until cpu_ack
// Notes:   APB slave with zero wait states; unmapped addresses give pslverr
// Notes on behaviour
// R1: Enabled window data reads fetch program memory at same address, table segment.
// R2: Window reads cost three extra cycles per byte, six per word.
// R3: Window writes cost no extra cycles; their result is not guaranteed.
// R4: Window low nibble is start top digit; high nibble end; bits 4,5 ones.
// R5: Zero low nibble disables the window.
// R6: Internal RAM inside the window wins over program memory.
// R7: Window addresses never reach external data memory.
// R8: Window bits 7:6 select end 3FFF, 7FFF, BFFF or FFFF.
// R9: Software keeps start at least 1200H in segment 0, else 1000H.
// R10: After any reset the window is inactive.
// R11: Window register takes only the first write after reset.
// R12: Hardware does not check start against end.
// R13: Program wait bits 1:0 give 0-3 waits; bit 2 applies to internal ROM.
// R14: Program wait bits 3,7 read one, ignore writes; bits 4-6 read zero.
// R15: Program wait register resets to 8BH.
// R16: Data wait bits 2:0 below 8000H, bits 6:4 from 8000H up.
// R17: Data wait bits 3,7 ignore writes and read one.
// R18: Data wait register resets to FFH.
// R19: External data bytes cost two base cycles each plus programmed waits.
// R20: Wait pin high, sampled on falling edges, stretches external strobes.
// R21: Wait ends one period after two consecutive low samples.
// R22: Programmed waits and wait pin together give the longer stretch.
// R23: Wait pin counts only when peripheral control bit 6 set, data space only.
`timescale 1ns/1ps
module emw_ctrl (
   input  wire logic                        mclk,
   input  wire logic                        sys_rst,
   input  wire logic [emw_pkg::PADDR_W-1:0] paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        cpu_req,
   input  wire logic                        cpu_prog_space,
   input  wire logic                        cpu_write,
   input  wire logic                        cpu_word,
   input  wire logic                        cpu_internal,
   input  wire logic [15:0]                 cpu_addr,
   input  wire logic [3:0]                  table_segment_select,
   output logic                             cpu_ack,
   output logic [19:0]                      mem_addr,
   output logic                             win_prog_read,
   output logic                             ext_prog_read,
   output logic                             ext_data_read,
   output logic                             ext_data_write,
   input  wire logic                        port11_pin0
);
   import emw_pkg::*;

   typedef struct packed {
      logic [7:0]       win;
      logic             win_locked;
      logic [2:0]       pw;
      logic [5:0]       dw;
      logic [7:0]       pc;
      logic [31:0]      rdata;
      logic             err;
      emw_state_e       state;
      logic [CNT_W-1:0] cnt;
      logic             wait_on;
      logic [19:0]      addr;
      logic             win_rd;
      logic             ext_prd;
      logic             ext_drd;
      logic             ext_dwr;
   } emw_ctrl_s;

   localparam emw_ctrl_s RST_ST = '{
      win:        RST_ROM_WINDOW,
      win_locked: 1'b0,
      pw:         RST_PROG_WAIT[2:0],
      dw:         {RST_DATA_WAIT[6:4], RST_DATA_WAIT[2:0]},
      pc:         RST_PERIPH_CTRL,
      rdata:      32'h0000_0000,
      err:        1'b0,
      state:      EMW_IDLE,
      cnt:        5'h00,
      wait_on:    1'b0,
      addr:       20'h0_0000,
      win_rd:     1'b0,
      ext_prd:    1'b0,
      ext_drd:    1'b0,
      ext_dwr:    1'b0
   };

   emw_ctrl_s st;
   emw_ctrl_s next_st;

   logic             stretch;
   logic             win_en;
   logic [15:0]      win_start;
   logic [15:0]      win_end;
   logic             in_win;
   logic             take;
   logic [CNT_W-1:0] cost;
   logic [2:0]       area_wait;
   logic [7:0]       pw_view;
   logic [7:0]       dw_view;
   logic             apb_setup;
   logic             apb_write;

   emw_wait_sampler u_wait (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .wait_pin (port11_pin0),
      .active   (st.wait_on && (st.ext_drd || st.ext_dwr)),   // R23
      .stretch  (stretch)
   );

   // Window decode; start above end simply matches nothing
   assign win_en    = st.win_locked && (st.win[3:0] != 4'h0);  // R5 R10
   assign win_start = {st.win[WIN_START_LSB +: 4], WIN_END_FILL & 12'h000}; // R4
   assign win_end   = {st.win[WIN_END_LSB +: 2], 2'b11, WIN_END_FILL};      // R8
   assign in_win    = win_en && (cpu_addr >= win_start) && (cpu_addr <= win_end); // R12

   assign take      = (st.state == EMW_IDLE) && cpu_req;
   assign area_wait = cpu_addr[15] ? st.dw[5:3] : st.dw[2:0];  // R16

   assign pw_view   = PW_READ_ONES | {5'b00000, st.pw};        // R14
   assign dw_view   = DW_READ_ONES | {1'b0, st.dw[5:3], 1'b0, st.dw[2:0]}; // R17
   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pwrite;

   // Cost of the access just taken
   always_comb begin
      cost = 5'h00;
      if (cpu_prog_space) begin
         if (!cpu_internal || st.pw[PW_INT_APPLY]) begin
            cost = {3'b000, st.pw[1:0]};                       // R13
         end
      end else if (cpu_internal) begin
         cost = 5'h00;                                         // R6
      end else if (in_win) begin
         if (!cpu_write) begin
            cost = cpu_word ? WIN_WORD_EXTRA : WIN_BYTE_EXTRA; // R2
         end
      end else begin
         // Base cost per byte, programmed waits once on top
         cost = (cpu_word ? 5'(EXT_BYTE_BASE << 1) : EXT_BYTE_BASE)
                + {2'b00, area_wait};                          // R19
      end
   end

   always_comb begin
      next_st = st;

      // Register reads are captured in setup so prdata comes from a flop
      if (apb_setup) begin
         next_st.err   = 1'b0;
         next_st.rdata = 32'h0000_0000;
         unique case (paddr)
            ADDR_ROM_WINDOW:  next_st.rdata = {24'h00_0000, st.win};
            ADDR_PROG_WAIT:   next_st.rdata = {24'h00_0000, pw_view};
            ADDR_DATA_WAIT:   next_st.rdata = {24'h00_0000, dw_view};
            ADDR_PERIPH_CTRL: next_st.rdata = {24'h00_0000, st.pc};
            default:          next_st.err   = 1'b1;
         endcase
      end

      if (apb_write) begin
         unique case (paddr)
            ADDR_ROM_WINDOW: begin
               if (!st.win_locked) begin
                  next_st.win        = pwdata[7:0];            // R11
                  next_st.win_locked = 1'b1;                   // R11
               end
            end
            ADDR_PROG_WAIT:   next_st.pw = pwdata[2:0];        // R14
            ADDR_DATA_WAIT:   next_st.dw = {pwdata[6:4], pwdata[2:0]}; // R17
            ADDR_PERIPH_CTRL: next_st.pc = pwdata[7:0];
            default: begin
            end
         endcase
      end

      unique case (st.state)
         EMW_IDLE: begin
            if (cpu_req) begin
               next_st.cnt     = cost;
               next_st.state   = (cost == 5'h00) ? EMW_DONE : EMW_COUNT;
               next_st.addr    = {table_segment_select, cpu_addr};   // R1
               next_st.win_rd  = !cpu_prog_space && !cpu_internal
                                 && in_win && !cpu_write;            // R1 R6
               next_st.ext_prd = cpu_prog_space && !cpu_internal;
               // Window area never goes out as ordinary data storage
               next_st.ext_drd = !cpu_prog_space && !cpu_internal
                                 && !in_win && !cpu_write;           // R7
               next_st.ext_dwr = !cpu_prog_space && !cpu_internal
                                 && !in_win && cpu_write;            // R3 R7
               next_st.wait_on = st.pc[PC_WAIT_ENABLE] && !cpu_prog_space; // R23
            end
         end
         EMW_COUNT: begin
            if (st.cnt > 5'h01) begin
               next_st.cnt = st.cnt - 5'h01;
            end else if (!(stretch && st.wait_on)) begin
               // Hold on last count while the pin asks; longer wait wins
               next_st.cnt   = 5'h00;                          // R22
               next_st.state = EMW_DONE;
            end
         end
         EMW_DONE: begin
            next_st.state   = EMW_IDLE;
            next_st.win_rd  = 1'b0;
            next_st.ext_prd = 1'b0;
            next_st.ext_drd = 1'b0;
            next_st.ext_dwr = 1'b0;
            next_st.wait_on = 1'b0;
         end
         default: begin
            next_st.state = EMW_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= RST_ST;                                         // R10 R15 R18
      end else begin
         st <= next_st;
      end
   end

   assign prdata         = st.rdata;
   assign pslverr        = st.err;
   assign pready         = 1'b1;
   assign cpu_ack        = (st.state == EMW_DONE);
   assign mem_addr       = st.addr;
   assign win_prog_read  = st.win_rd;
   assign ext_prog_read  = st.ext_prd;
   assign ext_data_read  = st.ext_drd;                         // R20
   assign ext_data_write = st.ext_dwr;                         // R20

   win_lock_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // R11
      st.win_locked && apb_write && (paddr == ADDR_ROM_WINDOW) |=> $stable(st.win))
      else $error("window register changed after first write");

   win_lock_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // R11
      !st.win_locked && apb_write && (paddr == ADDR_ROM_WINDOW) |=> st.win_locked)
      else $error("first window write did not lock the register");

   win_reset_off_a: assert property (@(posedge mclk) disable iff (sys_rst) // R10
      !st.win_locked |-> !win_en)
      else $error("window active before being written");

   win_zero_off_a: assert property (@(posedge mclk) disable iff (sys_rst) // R5
      (st.win[3:0] == 4'h0) |-> !in_win)
      else $error("window hit with zero start nibble");

   win_digit_hit_a: assert property (@(posedge mclk) disable iff (sys_rst) // R4 R8
      win_en && (cpu_addr[15:12] == st.win[3:0]) && (cpu_addr[15:14] <= st.win[7:6])
      |-> in_win)
      else $error("address inside window range missed");

   win_below_miss_a: assert property (@(posedge mclk) disable iff (sys_rst) // R4
      (cpu_addr[15:12] < st.win[3:0]) |-> !in_win)
      else $error("address below window start hit");

   win_above_miss_a: assert property (@(posedge mclk) disable iff (sys_rst) // R8
      (cpu_addr[15:14] > st.win[7:6]) |-> !in_win)
      else $error("address above window end hit");

   rdy_reset_val_a: assert property (@(posedge mclk) disable iff (sys_rst) // R15 R18
      $fell(sys_rst) |-> (pw_view == RST_PROG_WAIT) && (dw_view == RST_DATA_WAIT))
      else $error("wait registers not at reset values");

   pw_read_view_a: assert property (@(posedge mclk) disable iff (sys_rst) // R14
      apb_setup && (paddr == ADDR_PROG_WAIT) |=> (prdata[7:3] == 5'b10001))
      else $error("program wait fixed bits read wrong");

   dw_read_view_a: assert property (@(posedge mclk) disable iff (sys_rst) // R17
      apb_setup && (paddr == ADDR_DATA_WAIT) |=> prdata[7] && prdata[3])
      else $error("data wait fixed bits read wrong");

   seg_addr_out_a: assert property (@(posedge mclk) disable iff (sys_rst) // R1
      take |=> (mem_addr[15:0] == $past(cpu_addr))
      && (mem_addr[19:16] == $past(table_segment_select)))
      else $error("memory address not segment and address");

   win_read_route_a: assert property (@(posedge mclk) disable iff (sys_rst) // R1
      take && in_win && !cpu_prog_space && !cpu_internal && !cpu_write |=> win_prog_read)
      else $error("window read not served from program memory");

   win_byte_cost_a: assert property (@(posedge mclk) disable iff (sys_rst) // R2
      take && in_win && !cpu_prog_space && !cpu_internal && !cpu_write && !cpu_word
      |=> !cpu_ack [*3] ##1 cpu_ack)
      else $error("window byte read not three extra cycles");

   win_word_cost_a: assert property (@(posedge mclk) disable iff (sys_rst) // R2
      take && in_win && !cpu_prog_space && !cpu_internal && !cpu_write && cpu_word
      |=> !cpu_ack [*6] ##1 cpu_ack)
      else $error("window word read not six extra cycles");

   win_write_free_a: assert property (@(posedge mclk) disable iff (sys_rst) // R3
      take && in_win && !cpu_prog_space && !cpu_internal && cpu_write
      |=> cpu_ack && !ext_data_write)
      else $error("window write took extra cycles or went out");

   int_ram_first_a: assert property (@(posedge mclk) disable iff (sys_rst) // R6
      take && !cpu_prog_space && cpu_internal
      |=> !win_prog_read && !ext_data_read && !ext_data_write)
      else $error("internal RAM access was redirected");

   win_no_ext_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
      take && !cpu_prog_space && in_win |=> !ext_data_read && !ext_data_write)
      else $error("window address reached external data memory");

   wait_holds_a: assert property (@(posedge mclk) disable iff (sys_rst) // R22
      (st.state == EMW_COUNT) && (st.cnt == 5'h01) && stretch && st.wait_on
      |=> (st.state == EMW_COUNT))
      else $error("access ended while wait pin stretching");

   wait_off_end_a: assert property (@(posedge mclk) disable iff (sys_rst) // R23
      (st.state == EMW_COUNT) && (st.cnt == 5'h01) && !st.wait_on |=> (st.state == EMW_DONE))
      else $error("wait pin honoured while not enabled");

   strobe_stretch_a: assert property (@(posedge mclk) disable iff (sys_rst) // R20
      (ext_data_read || ext_data_write) && !cpu_ack |=> ext_data_read || ext_data_write)
      else $error("external data strobe dropped before access end");

   prog_ext_cost_a: assert property (@(posedge mclk) disable iff (sys_rst) // R13
      take && cpu_prog_space && !cpu_internal && (st.pw[1:0] == 2'b00) |=> cpu_ack)
      else $error("program fetch with zero waits was delayed");

   prog_int_free_a: assert property (@(posedge mclk) disable iff (sys_rst) // R13
      take && cpu_prog_space && cpu_internal && !st.pw[PW_INT_APPLY] |=> cpu_ack)
      else $error("internal program fetch got waits without apply bit");

   prog_wait_max_a: assert property (@(posedge mclk) disable iff (sys_rst) // R13
      take && cpu_prog_space && !cpu_internal && (st.pw[1:0] == 2'b11)
      |=> !cpu_ack [*3] ##1 cpu_ack)
      else $error("program fetch not three wait cycles");

   ext_byte_base_a: assert property (@(posedge mclk) disable iff (sys_rst) // R19
      take && !cpu_prog_space && !cpu_internal && !in_win && !cpu_word
      && (area_wait == 3'h0) && !st.pc[PC_WAIT_ENABLE] |=> !cpu_ack [*2] ##1 cpu_ack)
      else $error("external byte access not two base cycles");

   ext_word_base_a: assert property (@(posedge mclk) disable iff (sys_rst) // R19
      take && !cpu_prog_space && !cpu_internal && !in_win && cpu_word
      && (area_wait == 3'h0) && !st.pc[PC_WAIT_ENABLE] |=> !cpu_ack [*4] ##1 cpu_ack)
      else $error("external word access not four base cycles");
endmodule : emw_ctrl

// ===== common/emw_pkg.sv
// Purpose: Shared constants for the memory window and wait control block
// Assumes: APB byte address is four times the register index
// Notes:   Counts are in mclk cycles
package emw_pkg;
   localparam int PADDR_W = 8;
   localparam int CNT_W   = 5;

   // Register indices and byte addresses
   localparam logic [PADDR_W-1:0] IDX_ROM_WINDOW   = 8'h0b;
   localparam logic [PADDR_W-1:0] IDX_PROG_WAIT    = 8'h0c;
   localparam logic [PADDR_W-1:0] IDX_DATA_WAIT    = 8'h0d;
   localparam logic [PADDR_W-1:0] IDX_PERIPH_CTRL  = 8'h15;
   localparam logic [PADDR_W-1:0] ADDR_ROM_WINDOW  = 8'(IDX_ROM_WINDOW << 2);
   localparam logic [PADDR_W-1:0] ADDR_PROG_WAIT   = 8'(IDX_PROG_WAIT << 2);
   localparam logic [PADDR_W-1:0] ADDR_DATA_WAIT   = 8'(IDX_DATA_WAIT << 2);
   localparam logic [PADDR_W-1:0] ADDR_PERIPH_CTRL = 8'(IDX_PERIPH_CTRL << 2);

   // Reset values
   localparam logic [7:0] RST_ROM_WINDOW  = 8'h00;
   localparam logic [7:0] RST_PROG_WAIT   = 8'h8b;
   localparam logic [7:0] RST_DATA_WAIT   = 8'hff;
   localparam logic [7:0] RST_PERIPH_CTRL = 8'h8c;

   // Field positions
   localparam int WIN_START_LSB   = 0;
   localparam int WIN_END_LSB     = 6;
   localparam int PW_COUNT_LSB    = 0;
   localparam int PW_INT_APPLY    = 2;
   localparam int DW_LOW_LSB      = 0;
   localparam int DW_HIGH_LSB     = 4;
   localparam int PC_WAIT_ENABLE  = 6;

   // Fixed read bits
   localparam logic [7:0] PW_READ_ONES = 8'h88;
   localparam logic [7:0] DW_READ_ONES = 8'h88;

   // Access costs in cycles, and the fill for the window end address
   localparam logic [CNT_W-1:0] WIN_BYTE_EXTRA  = 5'h03;
   localparam logic [CNT_W-1:0] WIN_WORD_EXTRA  = 5'h06;
   localparam logic [CNT_W-1:0] EXT_BYTE_BASE   = 5'h02;
   localparam logic [11:0]      WIN_END_FILL    = 12'hfff;

   typedef enum logic [1:0] {
      EMW_IDLE  = 2'b00,
      EMW_COUNT = 2'b01,
      EMW_DONE  = 2'b10
   } emw_state_e;
endpackage : emw_pkg

// ===== design/emw_wait_sampler.sv
// Purpose: Samples the external wait pin on falling clock edges
// Assumes: Pin is synchronous to mclk; active frames one external data access
// Notes:   Stretch drops one sample period after two consecutive low samples
`timescale 1ns/1ps
module emw_wait_sampler (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic wait_pin,
   input  wire logic active,
   output logic      stretch
);
   import emw_pkg::*;

   typedef struct packed {
      logic       seen_high;
      logic [1:0] low_run;
   } emw_ws_s;

   emw_ws_s st;
   emw_ws_s next_st;

   always_comb begin
      next_st = st;
      if (!active) begin
         next_st.seen_high = 1'b0;
         next_st.low_run   = 2'b00;
      end else if (wait_pin) begin
         next_st.seen_high = 1'b1;                            // R20
         next_st.low_run   = 2'b00;
      end else if (st.low_run != 2'b11) begin
         next_st.low_run   = st.low_run + 2'b01;              // R21
      end
   end

   // Falling edge, as the pin is judged half a cycle ahead of the strobe end
   always_ff @(negedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign stretch = st.seen_high && (st.low_run != 2'b11);    // R21
endmodule : emw_wait_sampler

// ===== verification/emw_ext_mem.sv
// Purpose: Slow external memory that requests waits on data accesses
// Assumes: Data strobes stay high for the whole access
// Notes:   Wait length is set per access by the bench; zero means no wait
`timescale 1ns/1ps
module emw_ext_mem (
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       ext_data_read,
   input  wire logic       ext_data_write,
   input  wire logic [7:0] hold_len,
   output logic            port11_pin0
);
   logic [7:0] left;
   logic       seen;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         left <= 8'h00;
         seen <= 1'b0;
         port11_pin0 <= 1'b0;
      end else if (!(ext_data_read || ext_data_write)) begin
         // Request dies with the strobe so no wait leaks into the next access
         left <= 8'h00;
         seen <= 1'b0;
         port11_pin0 <= 1'b0;
      end else if (!seen) begin
         seen <= 1'b1;
         left <= hold_len;
         port11_pin0 <= (hold_len != 8'h00);
      end else if (left > 8'h01) begin
         left <= left - 8'h01;
      end else begin
         left <= 8'h00;
         port11_pin0 <= 1'b0;
      end
   end
endmodule : emw_ext_mem

// ===== verification/emw_ctrl_tb_top.sv
// Purpose: Self-checking bench for window mapping and wait insertion
// Assumes: APB answers when pready is high; CPU holds request until ack
// Notes:   Window takes one write per reset, so end codes loop over resets
`timescale 1ns/1ps
module emw_ctrl_tb_top;
   import emw_pkg::*;
   logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, cpu_ack, pin;
   logic cpu_req, cpu_prog_space, cpu_write, cpu_word, cpu_internal;
   logic win_prog_read, ext_prog_read, ext_data_read, ext_data_write;
   logic [PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd, r, seed;
   logic [15:0] cpu_addr;
   logic [3:0]  table_segment_select;
   logic [19:0] mem_addr;
   logic [7:0]  hold_len, pw, dw, pc, win;
   logic        er;
   int          bad_count, compares;
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   emw_ctrl i_emw_ctrl (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_req(cpu_req), .cpu_prog_space(cpu_prog_space),
      .cpu_write(cpu_write), .cpu_word(cpu_word), .cpu_internal(cpu_internal),
      .cpu_addr(cpu_addr), .table_segment_select(table_segment_select), .cpu_ack(cpu_ack),
      .mem_addr(mem_addr), .win_prog_read(win_prog_read), .ext_prog_read(ext_prog_read),
      .ext_data_read(ext_data_read), .ext_data_write(ext_data_write), .port11_pin0(pin));
   emw_ext_mem i_emw_ext_mem (.mclk(mclk), .sys_rst(sys_rst), .ext_data_read(ext_data_read),
      .ext_data_write(ext_data_write), .hold_len(hold_len), .port11_pin0(pin));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic hit(logic p, logic in, logic [15:0] a);
      return !p && !in && win[3:0] != 4'h0 && a[15:12] >= win[3:0]
         && a <= {win[7:6], 14'h3fff};
   endfunction : hit
   function automatic int exp_n(logic p, logic w, logic wd, logic in, logic [15:0] a);
      if (hit(p, in, a)) return w ? 0 : (wd ? 6 : 3);
      if (in && !p) return 0;
      if (p) return (in && !pw[2]) ? 0 : int'(pw[1:0]);
      return (wd ? 4 : 2) + int'(a[15] ? dw[6:4] : dw[2:0]);
   endfunction : exp_n
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rst();
      sys_rst <= 1'b1;
      cpu_req <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      pw = RST_PROG_WAIT;
      dw = RST_DATA_WAIT;
      pc = RST_PERIPH_CTRL;
      win = 8'h00;
   endtask : rst
   task automatic cpu(input logic p, w, wd, in, input logic [15:0] a, input int lo, hi);
      int n;
      int e;
      logic [3:0] sg;
      sg = 4'(xs());
      e = exp_n(p, w, wd, in, a) + 1;
      @(posedge mclk);
      cpu_req <= 1'b1;
      cpu_prog_space <= p;
      cpu_write <= w;
      cpu_word <= wd;
      cpu_internal <= in;
      cpu_addr <= a;
      table_segment_select <= sg;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (cpu_ack !== 1'b1 && n < 300);
      compares++;
      if (n < e + lo || n > e + hi) begin
         bad_count++;
         $display("unexpected latency expected %0d seen %0d", e, n);
      end
      chk("strobes", {hit(p, in, a) && !w, p && !in, !p && !in && !hit(p, in, a) && !w,
         !p && !in && !hit(p, in, a) && w},
         {win_prog_read, ext_prog_read, ext_data_read, ext_data_write});
      chk("mem_addr", {sg, a}, mem_addr);
      @(posedge mclk);
      cpu_req <= 1'b0;
   endtask : cpu
   task automatic test_done();
      $display("counts: %0d compares, %0d mismatches", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   initial begin
      {paddr, pwrite, pwdata, cpu_prog_space, cpu_write, cpu_word, cpu_internal} <= '0;
      {cpu_addr, table_segment_select, hold_len} <= '0;
      bad_count = 0;
      compares = 0;
      seed = 32'hddf4be4c;
      rst();
      apb(0, ADDR_PROG_WAIT, 0);
      chk("prog_wait", 32'h8b, rd);
      apb(0, ADDR_DATA_WAIT, 0);
      chk("data_wait", 32'hff, rd);
      apb(0, ADDR_PERIPH_CTRL, 0);
      chk("periph", 32'h8c, rd);
      apb(0, 8'h40, 0);
      chk("pslverr", 1, er);
      cpu(0, 0, 0, 0, 16'h3000, 0, 0);
      // Start above end: hardware must simply find no hit
      win = 8'h35;
      apb(1, ADDR_ROM_WINDOW, {24'h0, win});
      cpu(0, 0, 0, 0, 16'h5000, 0, 0);
      $display("test reset values done");
      for (int c = 0; c < 4; c++) begin
         rst();
         win = {c[1:0], 6'h32};
         apb(1, ADDR_ROM_WINDOW, {24'h0, win});
         apb(1, ADDR_ROM_WINDOW, 32'hf1);
         apb(0, ADDR_ROM_WINDOW, 0);
         chk("window", {24'h0, win}, rd);
         cpu(0, 0, c[0], 0, {c[1:0], 14'h3fff}, 0, 0);
         cpu(0, 0, 0, 0, {c[1:0], 14'h3fff} + 16'h1, 0, 0);
         cpu(0, 0, 0, 0, 16'h1fff, 0, 0);
         cpu(0, 1, 0, 0, 16'h2000, 0, 0);
         cpu(0, 0, 1, 1, 16'h2000, 0, 0);
      end
      $display("test window done");
      // Small window so random addresses also reach the high wait area
      rst();
      win = 8'h32;
      apb(1, ADDR_ROM_WINDOW, {24'h0, win});
      for (int i = 0; i < 60; i++) begin
         r = xs();
         if (i % 10 == 0) begin
            apb(1, ADDR_PROG_WAIT, {29'h0, r[6:4]});
            pw = {5'h11, r[6:4]};
            apb(0, ADDR_PROG_WAIT, 0);
            chk("prog_wait", {24'h0, pw}, rd);
            apb(1, ADDR_DATA_WAIT, r);
            dw = r[7:0] | DW_READ_ONES;
            apb(0, ADDR_DATA_WAIT, 0);
            chk("data_wait", {24'h0, dw}, rd);
         end
         cpu(r[0], r[1], r[2], r[3], r[31:16], 0, 0);
      end
      $display("test random done");
      apb(1, ADDR_DATA_WAIT, 0);
      dw = 8'h88;
      hold_len <= 8'h14;
      cpu(0, 0, 0, 0, 16'h1000, 0, 0);
      apb(1, ADDR_PERIPH_CTRL, 32'hcc);
      cpu(0, 0, 0, 0, 16'h1000, 17, 26);
      apb(1, ADDR_DATA_WAIT, 32'h77);
      dw = 8'hff;
      hold_len <= 8'h02;
      cpu(0, 1, 0, 0, 16'h9000, 0, 0);
      $display("test wait pin done");
      test_done();
   end
   initial begin
      #500000;
      bad_count++;
      test_done();
   end
endmodule : emw_ctrl_tb_top
